// ===== verilog/jesd_link_harness.sv
// link test harness: configuration sequencer, sysref, sample source and checker
// What this block does
// RL1: lane words 32 bits, stream lanes times 32
// RL2: two samples per lane word, one per frame
// RL3: sample bits 15:14 control, 13:0 sine
// RL4: same mapping on all lanes, no splitting
// RL5: sysref repeats every four multi-frames
// RL6: write link parameters, then reset value one
// RL7: poll reset register until bit clears
// RL8: octets per frame 2, written as 1
// RL9: frames per multi-frame 32, written 31
// RL10: lanes and converters written as lanes minus one
// RL11: resolution written 13, sample bits 15
// RL12: samples per converter written as 0
// RL13: scrambling 0, control words 1, bits 2
// RL14: subclass field written as 1
// RL15: generate mapped sine samples for the receiver
// RL16: receiver reports one pass bit on match
// RL17: check decoded aligned lanes for sine samples
// RL18: hold data until reset handshake completes
//
// Added by the designer: the register addresses and the Wishbone register port.
module jesd_link_harness
  import jesd_harness_pkg::*;
#(
  parameter int LANES = 2
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic [CORE_AW-1:0] m_awaddr_o,
  output logic m_awvalid_o,
  input wire logic m_awready_i,
  output logic [31:0] m_wdata_o,
  output logic [3:0] m_wstrb_o,
  output logic m_wvalid_o,
  input wire logic m_wready_i,
  input wire logic [1:0] m_bresp_i,
  input wire logic m_bvalid_i,
  output logic m_bready_o,
  output logic [CORE_AW-1:0] m_araddr_o,
  output logic m_arvalid_o,
  input wire logic m_arready_i,
  input wire logic [31:0] m_rdata_i,
  input wire logic [1:0] m_rresp_i,
  input wire logic m_rvalid_i,
  output logic m_rready_o,
  output logic sysref_o,
  output logic link_ready_o,
  output logic [LANES*LANE_W-1:0] src_tdata_o,
  output logic src_tvalid_o,
  input wire logic src_tready_i,
  input wire logic [LANES*LANE_W-1:0] chk_tdata_i,
  input wire logic chk_tvalid_i,
  input wire logic rx_pass_i
);

  initial begin
    if (LANES < 1 || LANES > MAX_LANES) $error("LANES must be 1 to 12");
  end

  // ------
  // types and state
  // ------
  typedef enum logic [2:0] {
    CS_IDLE = 3'b000,
    CS_WRITE = 3'b001,
    CS_RST = 3'b010,
    CS_POLL = 3'b011,
    CS_DONE = 3'b100
  } cfg_state_type;

  typedef struct packed {
    cfg_state_type st;
    logic [3:0] idx;
    logic req;
    logic we;
    logic [CORE_AW-1:0] addr;
    logic [31:0] wdata;
    logic axi_err;
    logic start;
    logic data_en;
    logic [15:0] sref_cnt;
    logic sysref;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic [LANES-1:0] lock;
    logic [LANES-1:0][3:0] phase;
    logic [15:0] err_cnt;
  } hs_type;

  localparam logic [15:0] SREF_LAST = 16'(SYSREF_PERIOD_CYC - 1);
  localparam logic [31:0] ENC_LANES = 32'(LANES - 1);

  hs_type s_reg, s_next;
  logic wb_req;
  logic [LANES-1:0] lane_hit;
  logic [LANES-1:0] lane_first;
  logic chk_ok;
  logic src_en;
  logic start_set;

  cfg_bus_if cfg ();

  // ------
  // parameter table walked by the sequencer
  // ------
  function automatic logic [CORE_AW+31:0] cfg_entry(input logic [3:0] i);
    case (i)
      4'h0: cfg_entry = {CORE_F_OFS, ENC_F}; // [RL8]
      4'h1: cfg_entry = {CORE_K_OFS, ENC_K}; // [RL9]
      4'h2: cfg_entry = {CORE_L_OFS, ENC_LANES}; // [RL10]
      4'h3: cfg_entry = {CORE_M_OFS, ENC_LANES}; // [RL10]
      4'h4: cfg_entry = {CORE_N_OFS, ENC_N}; // [RL11]
      4'h5: cfg_entry = {CORE_NP_OFS, ENC_NP}; // [RL11]
      4'h6: cfg_entry = {CORE_S_OFS, ENC_S}; // [RL12]
      4'h7: cfg_entry = {CORE_SCR_OFS, ENC_SCR}; // [RL13]
      4'h8: cfg_entry = {CORE_CF_OFS, ENC_CF}; // [RL13]
      4'h9: cfg_entry = {CORE_CS_OFS, ENC_CS}; // [RL13]
      default: cfg_entry = {CORE_SUBCLASS_OFS, ENC_SUBCLASS}; // [RL14]
    endcase
  endfunction

  // ------
  // per-lane comparison against the expected sine words
  // ------
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign lane_hit[g] =
        chk_tdata_i[g*LANE_W +: LANE_W] == lane_word(s_reg.phase[g]); // [RL17]
      assign lane_first[g] =
        chk_tdata_i[g*LANE_W +: LANE_W] == lane_word(4'h0); // [RL17]
    end
  endgenerate

  assign wb_req = wb_cyc_i && wb_stb_i && !s_reg.wb_ack;
  assign chk_ok = (&s_reg.lock) && (s_reg.err_cnt == 16'h0000);
  assign src_en = s_reg.data_en && (s_reg.st == CS_DONE); // [RL18]
  // a start written in the cycle it is taken survives: the set wins
  assign start_set = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == WB_CTRL_OFS) &&
    wb_dat_i[CTRL_START_BIT];

  // ------
  // next state
  // ------
  always_comb begin
    s_next = s_reg;
    s_next.wb_ack = 1'b0;

    // sysref: one-cycle pulse every four multi-frames
    if (s_reg.sref_cnt == SREF_LAST) begin
      s_next.sref_cnt = 16'h0000;
      s_next.sysref = 1'b1; // [RL5]
    end else begin
      s_next.sref_cnt = s_reg.sref_cnt + 16'h0001;
      s_next.sysref = 1'b0;
    end

    // wishbone slave, one wait state, unmapped reads zero
    if (wb_req) begin
      s_next.wb_ack = 1'b1;
      s_next.wb_dat = 32'h0000_0000;
      case (wb_adr_i)
        WB_CTRL_OFS: begin
          s_next.wb_dat[CTRL_DATA_EN_BIT] = s_reg.data_en;
          s_next.wb_dat[CTRL_START_BIT] = s_reg.start;
          if (wb_we_i && wb_sel_i[0]) begin
            s_next.data_en = wb_dat_i[CTRL_DATA_EN_BIT];
            if (wb_dat_i[CTRL_START_BIT]) s_next.start = 1'b1;
          end
        end
        WB_STATUS_OFS: begin
          s_next.wb_dat[ST_BUSY_BIT] = (s_reg.st != CS_IDLE) && (s_reg.st != CS_DONE);
          s_next.wb_dat[ST_DONE_BIT] = (s_reg.st == CS_DONE);
          s_next.wb_dat[ST_RX_PASS_BIT] = rx_pass_i; // [RL16]
          s_next.wb_dat[ST_CHK_OK_BIT] = chk_ok;
          s_next.wb_dat[ST_AXI_ERR_BIT] = s_reg.axi_err;
          s_next.wb_dat[ST_LOCK_LSB +: LANES] = s_reg.lock;
        end
        WB_ERRCNT_OFS: begin
          s_next.wb_dat[15:0] = s_reg.err_cnt;
          if (wb_we_i && wb_sel_i[0]) s_next.err_cnt = 16'h0000;
        end
        default: s_next.wb_dat = 32'h0000_0000;
      endcase
    end

    // configuration sequencer
    if (cfg.ack) begin
      s_next.req = 1'b0;
      if (cfg.err) s_next.axi_err = 1'b1;
    end
    case (s_reg.st)
      CS_IDLE: begin
        if (s_reg.start) begin
          s_next.start = start_set;
          s_next.axi_err = 1'b0;
          s_next.idx = 4'h0;
          s_next.st = CS_WRITE;
        end
      end
      CS_WRITE: begin
        if (!s_reg.req && !cfg.ack) begin
          s_next.req = 1'b1;
          s_next.we = 1'b1;
          {s_next.addr, s_next.wdata} = cfg_entry(s_reg.idx); // [RL6]
        end else if (cfg.ack) begin
          s_next.idx = s_reg.idx + 4'h1;
          if (s_reg.idx == CFG_WRITES - 4'h1) s_next.st = CS_RST;
        end
      end
      CS_RST: begin
        if (!s_reg.req && !cfg.ack) begin
          s_next.req = 1'b1;
          s_next.we = 1'b1;
          s_next.addr = CORE_RESET_OFS;
          s_next.wdata = CORE_RESET_GO; // [RL6]
        end else if (cfg.ack) begin
          s_next.st = CS_POLL;
        end
      end
      CS_POLL: begin
        if (!s_reg.req && !cfg.ack) begin
          s_next.req = 1'b1;
          s_next.we = 1'b0;
          s_next.addr = CORE_RESET_OFS;
        end else if (cfg.ack && !cfg.rdata[CORE_RESET_BIT]) begin
          s_next.st = CS_DONE; // [RL7]
        end
      end
      CS_DONE: begin
        if (s_reg.start) begin
          s_next.start = start_set;
          s_next.axi_err = 1'b0;
          s_next.idx = 4'h0;
          s_next.st = CS_WRITE;
        end
      end
      default: s_next.st = CS_IDLE;
    endcase

    // lane checker: lock on the first word of a period, then follow
    if (s_reg.st != CS_DONE) begin
      s_next.lock = '0; // [RL18]
    end else if (chk_tvalid_i) begin
      for (int i = 0; i < LANES; i++) begin
        if (!s_reg.lock[i]) begin
          if (lane_first[i]) begin
            s_next.lock[i] = 1'b1; // [RL17]
            s_next.phase[i] = PHASE_STEP;
          end
        end else if (lane_hit[i]) begin
          s_next.phase[i] = s_reg.phase[i] + PHASE_STEP;
        end else begin
          s_next.lock[i] = 1'b0;
        end
      end
      if (|(s_reg.lock & ~lane_hit) && s_next.err_cnt != ERRCNT_MAX) begin
        s_next.err_cnt = s_next.err_cnt + 16'h0001;
      end
    end
  end

  // ------
  // state register
  // ------
  always_ff @(posedge clk_i) begin
    if (rst_i) s_reg <= '0;
    else s_reg <= s_next;
  end

  // ------
  // sequencer drives the management master
  // ------
  assign cfg.req = s_reg.req && !cfg.ack;
  assign cfg.we = s_reg.we;
  assign cfg.addr = s_reg.addr;
  assign cfg.wdata = s_reg.wdata;

  axil_master u_axil (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg(cfg),
    .m_awaddr_o(m_awaddr_o),
    .m_awvalid_o(m_awvalid_o),
    .m_awready_i(m_awready_i),
    .m_wdata_o(m_wdata_o),
    .m_wstrb_o(m_wstrb_o),
    .m_wvalid_o(m_wvalid_o),
    .m_wready_i(m_wready_i),
    .m_bresp_i(m_bresp_i),
    .m_bvalid_i(m_bvalid_i),
    .m_bready_o(m_bready_o),
    .m_araddr_o(m_araddr_o),
    .m_arvalid_o(m_arvalid_o),
    .m_arready_i(m_arready_i),
    .m_rdata_i(m_rdata_i),
    .m_rresp_i(m_rresp_i),
    .m_rvalid_i(m_rvalid_i),
    .m_rready_o(m_rready_o)
  );

  // sine source towards the encoder of the receive lanes
  sample_mapper #(.LANES(LANES)) u_mapper (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(src_en), // [RL15]
    .ready_i(src_tready_i),
    .valid_o(src_tvalid_o),
    .data_o(src_tdata_o)
  );

  // ------
  // outputs
  // ------
  assign sysref_o = s_reg.sysref;
  assign link_ready_o = (s_reg.st == CS_DONE);
  assign wb_ack_o = s_reg.wb_ack;
  assign wb_dat_o = s_reg.wb_dat;

endmodule

// ===== shared/jesd_harness_pkg.sv
// constants, core register map and sample functions for the link test harness
package jesd_harness_pkg;

  // ------
  // lane and sample layout
  // ------
  localparam int LANE_W = 32;
  localparam int SAMPLE_W = 16;
  localparam int SINE_W = 14;
  localparam int CTRL_MSB = 15;
  localparam int CTRL_LSB = 14;
  localparam int SINE_MSB = 13;
  localparam int MAX_LANES = 12;
  localparam logic [3:0] PHASE_STEP = 4'h2;

  // ------
  // link parameters and their encoded values
  // ------
  localparam int OCTETS_PER_FRAME = 2;
  localparam int FRAMES_PER_MF = 32;
  localparam int MF_PER_SYSREF = 4;
  localparam int OCTETS_PER_CYCLE = 4;
  localparam int SYSREF_PERIOD_CYC =
    (MF_PER_SYSREF * FRAMES_PER_MF * OCTETS_PER_FRAME) / OCTETS_PER_CYCLE;
  localparam logic [31:0] ENC_F = 32'h0000_0001;
  localparam logic [31:0] ENC_K = 32'h0000_001f;
  localparam logic [31:0] ENC_N = 32'h0000_000d;
  localparam logic [31:0] ENC_NP = 32'h0000_000f;
  localparam logic [31:0] ENC_S = 32'h0000_0000;
  localparam logic [31:0] ENC_SCR = 32'h0000_0000;
  localparam logic [31:0] ENC_CF = 32'h0000_0001;
  localparam logic [31:0] ENC_CS = 32'h0000_0002;
  localparam logic [31:0] ENC_SUBCLASS = 32'h0000_0001;
  localparam logic [31:0] CORE_RESET_GO = 32'h0000_0001;
  localparam int CORE_RESET_BIT = 0;

  // ------
  // core register offsets (byte addresses on the management bus)
  // ------
  localparam int CORE_AW = 12;
  localparam logic [11:0] CORE_RESET_OFS = 12'h004;
  localparam logic [11:0] CORE_SCR_OFS = 12'h00c;
  localparam logic [11:0] CORE_SUBCLASS_OFS = 12'h010;
  localparam logic [11:0] CORE_F_OFS = 12'h020;
  localparam logic [11:0] CORE_K_OFS = 12'h024;
  localparam logic [11:0] CORE_L_OFS = 12'h028;
  localparam logic [11:0] CORE_M_OFS = 12'h02c;
  localparam logic [11:0] CORE_N_OFS = 12'h030;
  localparam logic [11:0] CORE_NP_OFS = 12'h034;
  localparam logic [11:0] CORE_S_OFS = 12'h038;
  localparam logic [11:0] CORE_CF_OFS = 12'h03c;
  localparam logic [11:0] CORE_CS_OFS = 12'h040;
  localparam logic [3:0] CFG_WRITES = 4'hb;

  // ------
  // own wishbone register map
  // ------
  localparam int WB_AW = 4;
  localparam logic [3:0] WB_CTRL_OFS = 4'h0;
  localparam logic [3:0] WB_STATUS_OFS = 4'h4;
  localparam logic [3:0] WB_ERRCNT_OFS = 4'h8;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DATA_EN_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_RX_PASS_BIT = 2;
  localparam int ST_CHK_OK_BIT = 3;
  localparam int ST_AXI_ERR_BIT = 4;
  localparam int ST_LOCK_LSB = 16;
  localparam logic [15:0] ERRCNT_MAX = 16'hffff;

  // ------
  // sample generation
  // ------
  // one sine period in 16 steps, two's complement
  function automatic logic [SINE_W-1:0] sine_value(input logic [3:0] ph);
    case (ph)
      4'h0: sine_value = 14'h0000;
      4'h1: sine_value = 14'h0bf5;
      4'h2: sine_value = 14'h1619;
      4'h3: sine_value = 14'h1cdf;
      4'h4: sine_value = 14'h1f40;
      4'h5: sine_value = 14'h1cdf;
      4'h6: sine_value = 14'h1619;
      4'h7: sine_value = 14'h0bf5;
      4'h8: sine_value = 14'h0000;
      4'h9: sine_value = 14'h340b;
      4'ha: sine_value = 14'h29e7;
      4'hb: sine_value = 14'h2321;
      4'hc: sine_value = 14'h20c0;
      4'hd: sine_value = 14'h2321;
      4'he: sine_value = 14'h29e7;
      default: sine_value = 14'h340b;
    endcase
  endfunction

  // control bits in [15:14], sine in [13:0]
  function automatic logic [SAMPLE_W-1:0] make_sample(input logic [3:0] ph);
    make_sample = {ph[1:0], sine_value(ph)};
  endfunction

  // two samples per lane word, older sample in the low half
  function automatic logic [LANE_W-1:0] lane_word(input logic [3:0] ph);
    lane_word = {make_sample(ph + 4'h1), make_sample(ph)};
  endfunction

endpackage

// ===== shared/cfg_bus_if.sv
// request and answer bus between the sequencer and the management master
interface cfg_bus_if;
  import jesd_harness_pkg::*;
  logic req;
  logic we;
  logic [CORE_AW-1:0] addr;
  logic [31:0] wdata;
  logic ack;
  logic err;
  logic [31:0] rdata;
  modport seq (output req, output we, output addr, output wdata,
               input ack, input err, input rdata);
  modport mst (input req, input we, input addr, input wdata,
               output ack, output err, output rdata);
endinterface

// ===== verilog/axil_master.sv
// single-access axi4-lite master driven from the configuration bus
module axil_master
  import jesd_harness_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  cfg_bus_if.mst cfg,
  output logic [CORE_AW-1:0] m_awaddr_o,
  output logic m_awvalid_o,
  input wire logic m_awready_i,
  output logic [31:0] m_wdata_o,
  output logic [3:0] m_wstrb_o,
  output logic m_wvalid_o,
  input wire logic m_wready_i,
  input wire logic [1:0] m_bresp_i,
  input wire logic m_bvalid_i,
  output logic m_bready_o,
  output logic [CORE_AW-1:0] m_araddr_o,
  output logic m_arvalid_o,
  input wire logic m_arready_i,
  input wire logic [31:0] m_rdata_i,
  input wire logic [1:0] m_rresp_i,
  input wire logic m_rvalid_i,
  output logic m_rready_o
);

  typedef enum logic [2:0] {
    AM_IDLE = 3'b000,
    AM_WRITE = 3'b001,
    AM_WRESP = 3'b010,
    AM_RADDR = 3'b011,
    AM_RDATA = 3'b100
  } am_state_type;

  typedef struct packed {
    am_state_type st;
    logic aw_done;
    logic w_done;
    logic [CORE_AW-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;
    logic err;
  } am_type;

  am_type s_reg, s_next;

  // ------
  // channel sequencing: write address and data together, then response; read address, then data
  // ------
  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    case (s_reg.st)
      AM_IDLE: begin
        if (cfg.req) begin
          s_next.addr = cfg.addr;
          s_next.wdata = cfg.wdata;
          s_next.aw_done = 1'b0;
          s_next.w_done = 1'b0;
          s_next.st = cfg.we ? AM_WRITE : AM_RADDR;
        end
      end
      AM_WRITE: begin
        if (m_awready_i) s_next.aw_done = 1'b1;
        if (m_wready_i) s_next.w_done = 1'b1;
        if ((s_reg.aw_done || m_awready_i) && (s_reg.w_done || m_wready_i)) begin
          s_next.st = AM_WRESP;
        end
      end
      AM_WRESP: begin
        if (m_bvalid_i) begin
          s_next.ack = 1'b1;
          s_next.err = m_bresp_i[1];
          s_next.st = AM_IDLE;
        end
      end
      AM_RADDR: begin
        if (m_arready_i) s_next.st = AM_RDATA;
      end
      AM_RDATA: begin
        if (m_rvalid_i) begin
          s_next.ack = 1'b1;
          s_next.err = m_rresp_i[1];
          s_next.rdata = m_rdata_i;
          s_next.st = AM_IDLE;
        end
      end
      default: s_next.st = AM_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) s_reg <= '0;
    else s_reg <= s_next;
  end

  // handshake outputs from state, payloads from flops
  assign m_awvalid_o = (s_reg.st == AM_WRITE) && !s_reg.aw_done;
  assign m_wvalid_o = (s_reg.st == AM_WRITE) && !s_reg.w_done;
  assign m_bready_o = (s_reg.st == AM_WRESP);
  assign m_arvalid_o = (s_reg.st == AM_RADDR);
  assign m_rready_o = (s_reg.st == AM_RDATA);
  assign m_awaddr_o = s_reg.addr;
  assign m_araddr_o = s_reg.addr;
  assign m_wdata_o = s_reg.wdata;
  assign m_wstrb_o = 4'hf;
  assign cfg.ack = s_reg.ack;
  assign cfg.err = s_reg.err;
  assign cfg.rdata = s_reg.rdata;

endmodule

// ===== verilog/sample_mapper.sv
// sine sample generator packing two samples per lane word on every lane
module sample_mapper
  import jesd_harness_pkg::*;
#(
  parameter int LANES = 2
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [LANES*LANE_W-1:0] data_o
);

  typedef struct packed {
    logic [3:0] phase;
    logic valid;
    logic [LANES*LANE_W-1:0] data;
  } sm_type;

  sm_type s_reg, s_next;

  // ------
  // advance one word when the consumer takes it
  // ------
  always_comb begin
    s_next = s_reg;
    if (en_i && (!s_reg.valid || ready_i)) begin
      s_next.data = {LANES{lane_word(s_reg.phase)}}; // [RL1] [RL2] [RL3] [RL4]
      s_next.phase = s_reg.phase + PHASE_STEP;
      s_next.valid = 1'b1;
    end else if (!en_i && ready_i) begin
      s_next.valid = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign valid_o = s_reg.valid;
  assign data_o = s_reg.data;

endmodule

// ===== verification/jesd_link_harness_assertions.sv
// concurrent checks on the ports of the link test harness
module jesd_link_harness_assertions
  import jesd_harness_pkg::*;
#(
  parameter int LANES = 2
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic m_awvalid_o,
  input wire logic m_awready_i,
  input wire logic m_wvalid_o,
  input wire logic [CORE_AW-1:0] m_awaddr_o,
  input wire logic m_arvalid_o,
  input wire logic [CORE_AW-1:0] m_araddr_o,
  input wire logic sysref_o,
  input wire logic link_ready_o,
  input wire logic [LANES*LANE_W-1:0] src_tdata_o,
  input wire logic src_tvalid_o,
  input wire logic src_tready_i
);
  // ------
  // helpers and properties
  // ------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic same;
  logic [1:0] ctl;
  assign ctl = src_tdata_o[15:14];
  // all lanes equal to lane zero
  always_comb begin
    same = 1'b1;
    for (int i = 1; i < LANES; i++) begin
      if (src_tdata_o[i*LANE_W +: LANE_W] != src_tdata_o[LANE_W-1:0]) same = 1'b0;
    end
  end
  property p_sysref; sysref_o |=> !sysref_o ##63 sysref_o; endproperty
  a_sysref: assert property (p_sysref) else $error("sysref spacing wrong");
  property p_hold; src_tvalid_o && !src_tready_i |=> src_tvalid_o && $stable(src_tdata_o); endproperty
  a_hold: assert property (p_hold) else $error("stream word dropped");
  property p_gate; src_tvalid_o |-> link_ready_o; endproperty
  a_gate: assert property (p_gate) else $error("data before link ready");
  property p_lanes; src_tvalid_o |-> same; endproperty
  a_lanes: assert property (p_lanes) else $error("lanes differ");
  property p_pair; src_tvalid_o |-> src_tdata_o[31:30] == ctl + 2'h1; endproperty
  a_pair: assert property (p_pair) else $error("sample pair order");
  property p_step; src_tvalid_o && src_tready_i ##1 src_tvalid_o |-> ctl == $past(ctl) + 2'h2;
  endproperty
  a_step: assert property (p_step) else $error("sample step wrong");
  property p_aw; m_awvalid_o && !m_awready_i |=> m_awvalid_o && $stable(m_awaddr_o); endproperty
  a_aw: assert property (p_aw) else $error("write address not held");
  property p_aww; $rose(m_awvalid_o) |-> m_wvalid_o; endproperty
  a_aww: assert property (p_aww) else $error("data not with address");
  property p_poll; m_arvalid_o |-> m_araddr_o == CORE_RESET_OFS; endproperty
  a_poll: assert property (p_poll) else $error("poll address wrong");
endmodule

bind jesd_link_harness jesd_link_harness_assertions #(.LANES(LANES)) checker_inst (.*);

// ===== verification/link_core_model.sv
// behavioural link core: management registers with a self-clearing reset bit
module link_core_model
  import jesd_harness_pkg::*;
#(
  parameter int HOLD = 6
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [CORE_AW-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [CORE_AW-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic pass_o
);
  logic [31:0] regs [0:31];
  logic tick = 1'b0;
  int n_wr;
  int n_at_go;
  int cnt;
  // ready only every other cycle, so waits are exercised
  assign awready_o = awvalid_i && wvalid_i && !bvalid_o && tick;
  assign wready_o = awready_o;
  assign arready_o = arvalid_i && !rvalid_o && tick;
  // register file, write and read responses
  always @(posedge clk_i) begin
    tick <= !tick;
    if (rst_i) begin
      bvalid_o <= 1'b0;
      rvalid_o <= 1'b0;
      pass_o <= 1'b0;
      n_wr <= 0;
      cnt <= 0;
    end else begin
      if (awready_o) begin
        regs[awaddr_i[6:2]] <= wdata_i;
        n_wr <= n_wr + 1;
        bvalid_o <= 1'b1;
        if (awaddr_i == CORE_RESET_OFS && wdata_i[0]) begin
          n_at_go <= n_wr;
          cnt <= HOLD;
        end
      end
      if (bvalid_o && bready_i) bvalid_o <= 1'b0;
      if (arready_o) begin
        rvalid_o <= 1'b1;
        rdata_o <= regs[araddr_i[6:2]];
      end
      if (rvalid_o && rready_i) begin
        rvalid_o <= 1'b0;
        rdata_o <= ~rdata_o;
      end
      // reset over: bit clears itself, receiver reports pass
      if (cnt == 1) begin
        regs[CORE_RESET_OFS[6:2]][0] <= 1'b0;
        pass_o <= 1'b1;
      end
      if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule

// ===== verification/test_jesd_link_harness.sv
// self-checking testbench for the link test harness
module test_jesd_link_harness
  import jesd_harness_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LANES = 2;
  localparam logic [31:0] LOCKS = 32'h0003_0000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic tready = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] bad = 32'h0;
  logic chk_tvalid = 1'b0;
  logic [LANES*32-1:0] chk_tdata = '0;
  logic [31:0] rdat, wdata, rdata;
  logic [11:0] awaddr, araddr;
  logic ack, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, ready, tvalid, pass;
  logic [LANES*32-1:0] tdata;
  int mismatches = 0;
  int n_compared = 0;
  jesd_link_harness #(.LANES(LANES)) jesd_link_harness_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .m_awaddr_o(awaddr), .m_awvalid_o(awvalid), .m_awready_i(awready), .m_wdata_o(wdata),
    .m_wstrb_o(), .m_wvalid_o(wvalid), .m_wready_i(wready), .m_bresp_i(2'h0),
    .m_bvalid_i(bvalid), .m_bready_o(bready), .m_araddr_o(araddr), .m_arvalid_o(arvalid),
    .m_arready_i(arready), .m_rdata_i(rdata), .m_rresp_i(2'h0), .m_rvalid_i(rvalid),
    .m_rready_o(rready), .sysref_o(), .link_ready_o(ready), .src_tdata_o(tdata),
    .src_tvalid_o(tvalid), .src_tready_i(tready), .chk_tdata_i(chk_tdata),
    .chk_tvalid_i(chk_tvalid), .rx_pass_i(pass));
  link_core_model link_core_model_inst (
    .clk_i(clk_i), .rst_i(rst_i), .awaddr_i(awaddr), .awvalid_i(awvalid),
    .awready_o(awready), .wdata_i(wdata), .wvalid_i(wvalid), .wready_o(wready),
    .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
    .arready_o(arready), .rdata_o(rdata), .rvalid_o(rvalid), .rready_i(rready),
    .pass_o(pass));
  // ------
  // clock, loopback and shared tasks
  // ------
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // returns the stream to the checker, optionally with a flipped bit
  always @(posedge clk_i) begin
    chk_tvalid <= tvalid && tready;
    chk_tdata <= tdata ^ {{(LANES-1)*32{1'b0}}, bad};
  end
  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 50) begin
      mismatches++;
      stop_test();
    end
  endtask
  // ------
  // scenarios
  // ------
  task automatic s_idle();
    logic [31:0] q;
    wb(1'b0, WB_STATUS_OFS, 32'h0, q);
    check(q, 32'h0);
    wb(1'b0, 4'hc, 32'h0, q);
    check(q, 32'h0);
    wb(1'b1, WB_CTRL_OFS, 32'h2, q);
    repeat (8) @(posedge clk_i);
    check({31'h0, tvalid}, 32'h0);
  endtask
  task automatic s_config();
    logic [31:0] q;
    logic [11:0] ofs [11] = '{CORE_F_OFS, CORE_K_OFS, CORE_L_OFS, CORE_M_OFS, CORE_N_OFS,
      CORE_NP_OFS, CORE_S_OFS, CORE_SCR_OFS, CORE_CF_OFS, CORE_CS_OFS, CORE_SUBCLASS_OFS};
    logic [31:0] val [11] = '{32'h1, 32'h1f, LANES-1, LANES-1, 32'hd, 32'hf, 32'h0, 32'h0,
      32'h1, 32'h2, 32'h1};
    int n;
    wb(1'b1, WB_CTRL_OFS, 32'h3, q);
    for (n = 0; n < 3000 && ready !== 1'b1; n++) @(posedge clk_i);
    check({31'h0, ready}, 32'h1);
    for (int i = 0; i < 11; i++) begin
      check(link_core_model_inst.regs[ofs[i][6:2]], val[i]);
    end
    check(link_core_model_inst.n_at_go, 32'd11);
    check(link_core_model_inst.regs[CORE_RESET_OFS[6:2]], 32'h0);
    wb(1'b0, WB_STATUS_OFS, 32'h0, q);
    check(q & 32'h7, 32'h6);
  endtask
  task automatic s_stream();
    logic [31:0] q;
    int n;
    for (n = 0; n < 100 && tvalid !== 1'b1; n++) @(posedge clk_i);
    check(tdata[31:0], 32'h4bf5_0000);
    check(tdata[63:32], 32'h4bf5_0000);
    tready <= 1'b1;
    repeat (2) @(posedge clk_i);
    check(tdata[31:0], 32'hdcdf_9619);
    tready <= 1'b0;
    repeat (3) @(posedge clk_i);
    tready <= 1'b1;
    repeat (20) @(posedge clk_i);
    wb(1'b0, WB_STATUS_OFS, 32'h0, q);
    check(q & (LOCKS | 32'h8), LOCKS | 32'h8);
    bad <= 32'h1;
    @(posedge clk_i);
    bad <= 32'h0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, WB_ERRCNT_OFS, 32'h0, q);
    check(q, 32'h1);
    wb(1'b0, WB_STATUS_OFS, 32'h0, q);
    check(q & 32'h8, 32'h0);
    wb(1'b1, WB_ERRCNT_OFS, 32'h0, q);
    wb(1'b0, WB_ERRCNT_OFS, 32'h0, q);
    check(q, 32'h0);
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    s_idle();
    s_config();
    s_stream();
    stop_test();
  end
endmodule
